// ==== atc_xfer_decode.v ====
`timescale 1ns/10ps
`default_nettype none
`include "atc_defs.vh"

module atc_xfer_decode #(
    parameter [9:0] OP_TMR_THIRD = `ATC_OP_TMR_THIRD_DFLT,
    parameter [9:0] OP_TMR_FIFTH = `ATC_OP_TMR_FIFTH_DFLT
) (
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    input wire instr_valid,
    input wire [9:0] instr_word,
    input wire [3:0] acc_val,
    output reg [3:0] irq_ctrl_first_r,
    output reg [3:0] irq_ctrl_second_r,
    output reg [3:0] tmr_ctrl_first_r,
    output reg [3:0] tmr_ctrl_second_r,
    output reg [3:0] tmr_ctrl_third_r,
    output reg [3:0] tmr_ctrl_fourth_r,
    output reg [3:0] tmr_ctrl_fifth_r,
    output reg [3:0] tmr_ctrl_sixth_r,
    output reg [7:0] wr_strobe_r,
    output reg exec_done_r,
    output reg skip_next_r,
    output reg carry_we_r
);

    wire [7:0] op_sel;
    wire [7:0] op_pick;
    wire any_hit;
    wire take;

    // Next-state values; the clocked processes below only copy them on an enabled edge
    reg [3:0] irq_ctrl_first_nxt;
    reg [3:0] irq_ctrl_second_nxt;
    reg [3:0] tmr_ctrl_first_nxt;
    reg [3:0] tmr_ctrl_second_nxt;
    reg [3:0] tmr_ctrl_third_nxt;
    reg [3:0] tmr_ctrl_fourth_nxt;
    reg [3:0] tmr_ctrl_fifth_nxt;
    reg [3:0] tmr_ctrl_sixth_nxt;
    reg [7:0] wr_strobe_nxt;
    reg exec_done_nxt;
    reg skip_next_nxt;
    reg carry_we_nxt;

    // An overridden opcode that collides with a fixed one would raise two selects;
    // the lowest select wins, so one instruction never writes two registers.
    // Default opcodes never collide, so this costs only a few gates
    function [7:0] pick_lowest;
        input [7:0] sel;
        reg [7:0] neg;
        begin
            neg = ~sel + 8'h01;
            pick_lowest = sel & neg;
        end
    endfunction

    // Shared load mux: the selected register takes the accumulator, all others keep theirs
    function [3:0] ld_next;
        input hit;
        input [3:0] cur;
        input [3:0] acc;
        begin
            if (hit) begin
                ld_next = acc;
            end else begin
                ld_next = cur;
            end
        end
    endfunction

    assign take = clk_en & instr_valid;
    // Recognise flag follows the picked select, so it always agrees with the strobe
    assign op_pick = pick_lowest(op_sel);
    assign any_hit = |op_pick;

    // The exact ten-bit match lives in the matcher
    atc_op_match #(
        .OP_TMR_THIRD(OP_TMR_THIRD),
        .OP_TMR_FIFTH(OP_TMR_FIFTH)
    ) u_match (
        .op_valid(take),
        .op_word(instr_word),
        .op_sel(op_sel)
    );

    // The accumulator is only read here; no path in this block can drive it
    always @* begin
        irq_ctrl_first_nxt = ld_next(op_pick[`ATC_SEL_IRQ_FIRST], irq_ctrl_first_r, acc_val);
        irq_ctrl_second_nxt = ld_next(op_pick[`ATC_SEL_IRQ_SECOND], irq_ctrl_second_r, acc_val);
        tmr_ctrl_first_nxt = ld_next(op_pick[`ATC_SEL_TMR_FIRST], tmr_ctrl_first_r, acc_val);
        tmr_ctrl_second_nxt = ld_next(op_pick[`ATC_SEL_TMR_SECOND], tmr_ctrl_second_r, acc_val);
        tmr_ctrl_third_nxt = ld_next(op_pick[`ATC_SEL_TMR_THIRD], tmr_ctrl_third_r, acc_val);
        tmr_ctrl_fourth_nxt = ld_next(op_pick[`ATC_SEL_TMR_FOURTH], tmr_ctrl_fourth_r, acc_val);
        tmr_ctrl_fifth_nxt = ld_next(op_pick[`ATC_SEL_TMR_FIFTH], tmr_ctrl_fifth_r, acc_val);
        tmr_ctrl_sixth_nxt = ld_next(op_pick[`ATC_SEL_TMR_SIXTH], tmr_ctrl_sixth_r, acc_val);
    end

    // Status pulses come from the same pick as the data path
    always @* begin
        wr_strobe_nxt = op_pick;
        exec_done_nxt = any_hit;
        // These transfers never skip and never touch the carry flag
        skip_next_nxt = 1'b0;
        carry_we_nxt = 1'b0;
    end

    // Clock enable low freezes every register, data and status alike
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ctrl_first_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            irq_ctrl_first_r <= irq_ctrl_first_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ctrl_second_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            irq_ctrl_second_r <= irq_ctrl_second_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_first_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_first_r <= tmr_ctrl_first_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_second_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_second_r <= tmr_ctrl_second_nxt;
        end
    end

    // Opcode is a parameter so that an integration can set its own encoding
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_third_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_third_r <= tmr_ctrl_third_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_fourth_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_fourth_r <= tmr_ctrl_fourth_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_fifth_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_fifth_r <= tmr_ctrl_fifth_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_ctrl_sixth_r <= `ATC_CTRL_RST;
        end else if (clk_en) begin
            tmr_ctrl_sixth_r <= tmr_ctrl_sixth_nxt;
        end
    end

    // Status pulses last one enabled cycle; a frozen clock enable holds them
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_strobe_r <= `ATC_STROBE_RST;
        end else if (clk_en) begin
            wr_strobe_r <= wr_strobe_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            exec_done_r <= 1'b0;
        end else if (clk_en) begin
            exec_done_r <= exec_done_nxt;
        end
    end

    // Kept as flops so that every top-level output leaves a register
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            skip_next_r <= 1'b0;
        end else if (clk_en) begin
            skip_next_r <= skip_next_nxt;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            carry_we_r <= 1'b0;
        end else if (clk_en) begin
            carry_we_r <= carry_we_nxt;
        end
    end

endmodule
`default_nettype wire

// ==== atc_defs.vh ====
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH

`define ATC_OP_W 10
`define ATC_ACC_W 4
`define ATC_NUM_DEST 8

`define ATC_OP_IRQ_FIRST 10'h03f
`define ATC_OP_IRQ_SECOND 10'h03e
`define ATC_OP_TMR_FIRST 10'h20e
`define ATC_OP_TMR_SECOND 10'h20f
`define ATC_OP_TMR_THIRD_DFLT 10'h210
`define ATC_OP_TMR_FOURTH 10'h211
`define ATC_OP_TMR_FIFTH_DFLT 10'h212
`define ATC_OP_TMR_SIXTH 10'h213

`define ATC_SEL_IRQ_FIRST 0
`define ATC_SEL_IRQ_SECOND 1
`define ATC_SEL_TMR_FIRST 2
`define ATC_SEL_TMR_SECOND 3
`define ATC_SEL_TMR_THIRD 4
`define ATC_SEL_TMR_FOURTH 5
`define ATC_SEL_TMR_FIFTH 6
`define ATC_SEL_TMR_SIXTH 7

`define ATC_CTRL_RST 4'h0
`define ATC_STROBE_RST 8'h00
`define ATC_EXEC_CYCLES 1

`endif

// ==== atc_op_match.v ====
`timescale 1ns/10ps
`default_nettype none
`include "atc_defs.vh"

module atc_op_match #(
    parameter [9:0] OP_TMR_THIRD = `ATC_OP_TMR_THIRD_DFLT,
    parameter [9:0] OP_TMR_FIFTH = `ATC_OP_TMR_FIFTH_DFLT
) (
    input wire op_valid,
    input wire [9:0] op_word,
    output reg [7:0] op_sel
);

    // Full ten-bit compare; partial decoding would alias neighbouring opcodes
    function op_hit;
        input [9:0] word;
        input [9:0] code;
        begin
            op_hit = (word == code);
        end
    endfunction

    always @* begin
        op_sel = `ATC_STROBE_RST;
        if (op_valid) begin
            op_sel[`ATC_SEL_IRQ_FIRST] = op_hit(op_word, `ATC_OP_IRQ_FIRST);
            op_sel[`ATC_SEL_IRQ_SECOND] = op_hit(op_word, `ATC_OP_IRQ_SECOND);
            op_sel[`ATC_SEL_TMR_FIRST] = op_hit(op_word, `ATC_OP_TMR_FIRST);
            op_sel[`ATC_SEL_TMR_SECOND] = op_hit(op_word, `ATC_OP_TMR_SECOND);
            op_sel[`ATC_SEL_TMR_THIRD] = op_hit(op_word, OP_TMR_THIRD);
            op_sel[`ATC_SEL_TMR_FOURTH] = op_hit(op_word, `ATC_OP_TMR_FOURTH);
            op_sel[`ATC_SEL_TMR_FIFTH] = op_hit(op_word, OP_TMR_FIFTH);
            op_sel[`ATC_SEL_TMR_SIXTH] = op_hit(op_word, `ATC_OP_TMR_SIXTH);
        end
    end

endmodule
`default_nettype wire

// ==== atc_xfer_decode_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "atc_defs.vh"
module atc_chk #(
    parameter [9:0] OP_TMR_THIRD = `ATC_OP_TMR_THIRD_DFLT,
    parameter [9:0] OP_TMR_FIFTH = `ATC_OP_TMR_FIFTH_DFLT
) (
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    input wire instr_valid,
    input wire [9:0] instr_word,
    input wire [3:0] acc_val,
    input wire [3:0] irq_ctrl_first_r,
    input wire [3:0] irq_ctrl_second_r,
    input wire [3:0] tmr_ctrl_first_r,
    input wire [3:0] tmr_ctrl_second_r,
    input wire [3:0] tmr_ctrl_third_r,
    input wire [3:0] tmr_ctrl_fourth_r,
    input wire [3:0] tmr_ctrl_fifth_r,
    input wire [3:0] tmr_ctrl_sixth_r,
    input wire [7:0] wr_strobe_r,
    input wire exec_done_r,
    input wire skip_next_r,
    input wire carry_we_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_t(logic [9:0] op);
        clk_en && instr_valid && instr_word == op;
    endsequence
    property p_irq1; s_t(10'h03f) |=> irq_ctrl_first_r == $past(acc_val) && wr_strobe_r == 8'h01; endproperty
    a_irq1: assert property (p_irq1) else $error("irq1 load");
    property p_irq2; s_t(10'h03e) |=> irq_ctrl_second_r == $past(acc_val); endproperty
    a_irq2: assert property (p_irq2) else $error("irq2 load");
    property p_tmr1; s_t(10'h20e) |=> tmr_ctrl_first_r == $past(acc_val); endproperty
    a_tmr1: assert property (p_tmr1) else $error("tmr1 load");
    property p_tmr2; s_t(10'h20f) |=> tmr_ctrl_second_r == $past(acc_val); endproperty
    a_tmr2: assert property (p_tmr2) else $error("tmr2 load");
    property p_tmr4; s_t(10'h211) |=> tmr_ctrl_fourth_r == $past(acc_val); endproperty
    a_tmr4: assert property (p_tmr4) else $error("tmr4 load");
    property p_tmr6; s_t(10'h213) |=> tmr_ctrl_sixth_r == $past(acc_val) && exec_done_r; endproperty
    a_tmr6: assert property (p_tmr6) else $error("tmr6 load");
    property p_quiet; !skip_next_r && !carry_we_r; endproperty
    a_quiet: assert property (p_quiet) else $error("skip or carry");
    property p_idle; clk_en && !instr_valid |=> wr_strobe_r == 8'h00 && !exec_done_r; endproperty
    a_idle: assert property (p_idle) else $error("idle write");
    property p_tmr3; s_t(OP_TMR_THIRD) |=> tmr_ctrl_third_r == $past(acc_val) && wr_strobe_r == 8'h10; endproperty
    a_tmr3: assert property (p_tmr3) else $error("tmr3 load");
    property p_tmr5; s_t(OP_TMR_FIFTH) |=> tmr_ctrl_fifth_r == $past(acc_val) && wr_strobe_r == 8'h40; endproperty
    a_tmr5: assert property (p_tmr5) else $error("tmr5 load");
    sequence s_other;
        clk_en && instr_valid && instr_word != 10'h03f && instr_word != 10'h03e && instr_word != 10'h20e
            && instr_word != 10'h20f && instr_word != OP_TMR_THIRD && instr_word != 10'h211
            && instr_word != OP_TMR_FIFTH && instr_word != 10'h213;
    endsequence
    sequence s_regs_held;
        $stable(irq_ctrl_first_r) && $stable(irq_ctrl_second_r) && $stable(tmr_ctrl_first_r)
            && $stable(tmr_ctrl_second_r) && $stable(tmr_ctrl_third_r) && $stable(tmr_ctrl_fourth_r)
            && $stable(tmr_ctrl_fifth_r) && $stable(tmr_ctrl_sixth_r);
    endsequence
    property p_other; s_other |=> s_regs_held ##0 (wr_strobe_r == 8'h00 && !exec_done_r); endproperty
    a_other: assert property (p_other) else $error("unassigned opcode wrote");
    property p_freeze; !clk_en |=> s_regs_held ##0 ($stable(wr_strobe_r) && $stable(exec_done_r)); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    property p_onehot; $onehot0(wr_strobe_r) && exec_done_r == (wr_strobe_r != 8'h00); endproperty
    a_onehot: assert property (p_onehot) else $error("strobe not one-hot");
endmodule
bind atc_xfer_decode atc_chk #(.OP_TMR_THIRD(OP_TMR_THIRD), .OP_TMR_FIFTH(OP_TMR_FIFTH)) chk_u (.*);
`default_nettype wire

// ==== test_acc_to_ctrl_reg_transfer_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_acc_to_ctrl_reg_transfer_decode;
    logic sys_clk = 0, rst_b = 0, clk_en = 0, instr_valid = 0;
    logic [9:0] instr_word = 10'h000;
    logic [3:0] acc_val = 4'h0, irq_ctrl_first_r, irq_ctrl_second_r, tmr_ctrl_first_r, tmr_ctrl_second_r;
    logic [3:0] tmr_ctrl_third_r, tmr_ctrl_fourth_r, tmr_ctrl_fifth_r, tmr_ctrl_sixth_r;
    logic [7:0] wr_strobe_r;
    logic exec_done_r, skip_next_r, carry_we_r;
    logic [31:0] m = 32'h0;
    int err_count = 0, n_checks = 0, cyc = 0;
    logic [21:0] rows [0:9] = '{{10'h03f, 4'h9, 8'h01}, {10'h03e, 4'ha, 8'h02}, {10'h20e, 4'h5, 8'h04},
        {10'h20f, 4'hc, 8'h08}, {10'h210, 4'h3, 8'h10}, {10'h211, 4'hf, 8'h20}, {10'h212, 4'h6, 8'h40},
        {10'h213, 4'h1, 8'h80}, {10'h03d, 4'h7, 8'h00}, {10'h23f, 4'he, 8'h00}};
    atc_xfer_decode dut_u (.*);
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 500) begin
            err_count++;
            final_report();
        end
    end
    task chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task run(input logic [9:0] op, input logic [3:0] a, input logic v, e, input logic [7:0] st);
        @(posedge sys_clk);
        instr_word <= op;
        acc_val <= a;
        instr_valid <= v;
        clk_en <= e;
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 8; i++) if (st[i] && e) m[4*i+:4] = a;
        chk(wr_strobe_r, st);
        chk(exec_done_r, |st);
        chk({skip_next_r, carry_we_r}, 0);
        chk({tmr_ctrl_sixth_r, tmr_ctrl_fifth_r, tmr_ctrl_fourth_r, tmr_ctrl_third_r, tmr_ctrl_second_r,
            tmr_ctrl_first_r, irq_ctrl_second_r, irq_ctrl_first_r}, m);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1;
        #1 chk(wr_strobe_r, 0);
        $display("reset end");
        foreach (rows[k]) begin
            run(rows[k][21:12], rows[k][11:8], 1, 1, rows[k][7:0]);
            $display("row %0d end", k);
        end
        run(10'h03f, 4'h6, 0, 1, 8'h00);
        run(10'h213, 4'h3, 1, 1, 8'h80);
        // Frozen clock enable holds the strobe and blocks the write
        run(10'h03f, 4'hc, 1, 0, 8'h80);
        $display("awkward cases end");
        // Reset in mid-run clears every register; the first load after it must land
        @(posedge sys_clk);
        rst_b <= 0;
        instr_valid <= 0;
        #1;
        m = 32'h0;
        chk({tmr_ctrl_sixth_r, tmr_ctrl_fifth_r, tmr_ctrl_fourth_r, tmr_ctrl_third_r, tmr_ctrl_second_r,
            tmr_ctrl_first_r, irq_ctrl_second_r, irq_ctrl_first_r}, m);
        chk({wr_strobe_r, exec_done_r}, 0);
        @(posedge sys_clk);
        rst_b <= 1;
        run(10'h20e, 4'h5, 1, 1, 8'h04);
        $display("mid-run reset end");
        final_report();
    end
endmodule
`default_nettype wire
